// ---- src/itoc_pkg.sv ----
// Constants and types shared by the inverse time overcurrent block.
// Summary of operation
// - Definite mode trips a phase after current stays above start for the fixed delay.
// - Inverse operate time is multiplier times k over ratio-power minus one, plus c.
// - IEC curve constants: normal, very, extremely and long inverse as tabulated.
// - ANSI operate constants for the seven ANSI curves as tabulated.
// - The current ratio is clamped at twenty, fixing operate time above it.
// - A longer minimum delay replaces the inverse curve operate time.
// - Inverse curves are guaranteed to operate above 1.1 times start current; the code starts timing at any current above start.
// - IEC curves reset after the fixed reset delay spent below start.
// - ANSI reset time is multiplier times kr over one minus ratio-power.
// - ANSI reset uses alpha two and the tabulated kr values.
// - Each phase is judged alone on its fundamental RMS magnitude.
// - Trip results of all phases are combined in a decision stage.
// - Each phase shows started above start, and trip when its delay expired.
// - The external block input suppresses every start and trip output.
// - General start is any phase started, general trip any phase tripped.
package itoc_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS     = 10;
  localparam int          SAMPLE_PERIOD_US  = 1000;
  localparam int          SAMPLE_CYCLES_DEF = SAMPLE_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam logic [63:0] TS_TENTHS_MS      = 64'(SAMPLE_PERIOD_US / 100);
  localparam logic [63:0] TENTHS_PER_MS     = 64'hA;
  localparam logic [63:0] TMS_SCALE         = 64'h64;

  // ---------------------------------------------------------------------------
  // Fixed point
  // ---------------------------------------------------------------------------
  localparam int          CUR_W       = 16;
  localparam logic [24:0] ACC_FULL    = 25'h1000000;
  localparam logic [31:0] RATIO_ONE   = 32'h00010000;
  localparam logic [31:0] RATIO_SAT   = 32'h00140000;
  localparam logic [63:0] LN_ALPHA002 = 64'h38D;
  localparam logic [63:0] FULL_TS     = 64'(ACC_FULL) * TS_TENTHS_MS;
  localparam logic [63:0] OP_SCALE    = FULL_TS * TMS_SCALE;

  // ---------------------------------------------------------------------------
  // Register map and reset values
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_START      = 8'h04;
  localparam logic [7:0]  REG_TMS        = 8'h08;
  localparam logic [7:0]  REG_MIN_DELAY  = 8'h0C;
  localparam logic [7:0]  REG_DEF_DELAY  = 8'h10;
  localparam logic [7:0]  REG_RST_DELAY  = 8'h14;
  localparam logic [7:0]  REG_STATUS     = 8'h18;
  localparam logic [7:0]  REG_IRQ_STAT   = 8'h1C;
  localparam logic [7:0]  REG_IRQ_MASK   = 8'h20;
  localparam logic [3:0]  CTRL_RST       = 4'h0;
  localparam logic [15:0] START_RST      = 16'h00C8;
  localparam logic [15:0] TMS_RST        = 16'h00C8;
  localparam logic [15:0] DELAY_RST      = 16'h0064;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_OFF = 4'h0, MODE_DEFINITE = 4'h1,
    MODE_IEC_INV = 4'h2, MODE_IEC_VERY = 4'h3, MODE_IEC_EXT = 4'h4, MODE_IEC_LONG = 4'h5,
    MODE_ANSI_INV = 4'h6, MODE_ANSI_MOD = 4'h7, MODE_ANSI_VERY = 4'h8, MODE_ANSI_EXT = 4'h9,
    MODE_ANSI_LONG = 4'hA, MODE_ANSI_LVERY = 4'hB, MODE_ANSI_LEXT = 4'hC
  } itoc_mode_t;

  typedef enum logic [1:0] {ALPHA_002 = 2'h0, ALPHA_1 = 2'h1, ALPHA_2 = 2'h2} itoc_alpha_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000, SEQ_MIN = 3'b001, SEQ_DEF = 3'b011, SEQ_RATIO = 3'b010,
    SEQ_UPDATE = 3'b110
  } itoc_seq_t;

  // Curve constants in tenths of a millisecond.
  typedef struct packed {
    logic [23:0] k;
    logic [23:0] c;
    logic [23:0] kr;
    itoc_alpha_t alpha;
  } itoc_curve_t;

  typedef struct packed {
    logic [2:0] trip;
    logic [2:0] start;
  } itoc_flags_t;

  function automatic itoc_curve_t curve_of(input logic [3:0] mode);
    itoc_curve_t cv;
    cv = '{k: 24'h0, c: 24'h0, kr: 24'h0, alpha: ALPHA_1};
    unique case (mode)
      MODE_IEC_INV:    cv = '{24'h000578, 24'h0,      24'h0,      ALPHA_002};
      MODE_IEC_VERY:   cv = '{24'h020F58, 24'h0,      24'h0,      ALPHA_1};
      MODE_IEC_EXT:    cv = '{24'h0C3500, 24'h0,      24'h0,      ALPHA_2};
      MODE_IEC_LONG:   cv = '{24'h124F80, 24'h0,      24'h0,      ALPHA_1};
      MODE_ANSI_INV:   cv = '{24'h000056, 24'h0000B9, 24'h0011F8, ALPHA_002};
      MODE_ANSI_MOD:   cv = '{24'h000203, 24'h000474, 24'h00BD74, ALPHA_002};
      MODE_ANSI_VERY:  cv = '{24'h02FE04, 24'h00132E, 24'h034BC0, ALPHA_2};
      MODE_ANSI_EXT:   cv = '{24'h044D90, 24'h0004C1, 24'h0470B8, ALPHA_2};
      MODE_ANSI_LONG:  cv = '{24'h00035C, 24'h00073A, 24'h00B3B0, ALPHA_002};
      MODE_ANSI_LVERY: cv = '{24'h045B3C, 24'h001BD0, 24'h020DC8, ALPHA_2};
      MODE_ANSI_LEXT:  cv = '{24'h09C6BC, 24'h0009C4, 24'h0493E0, ALPHA_2};
      default:         cv = '{k: 24'h0, c: 24'h0, kr: 24'h0, alpha: ALPHA_1};
    endcase
    return cv;
  endfunction : curve_of

endpackage : itoc_pkg

// ---- src/itoc_core.sv ----
// Three-phase inverse time overcurrent decision block with AXI4-Lite settings.
`timescale 1ns/1ps
module itoc_core
  import itoc_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DEF
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rstn,
  input  wire logic [CUR_W-1:0]  i_phase1_fundamental_rms,
  input  wire logic [CUR_W-1:0]  i_phase2_fundamental_rms,
  input  wire logic [CUR_W-1:0]  i_phase3_fundamental_rms,
  input  wire logic              i_block,
  output itoc_flags_t            o_phase_flags,
  output logic                   o_general_start,
  output logic                   o_general_trip,
  output logic                   o_irq,
  input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic              i_s_axi_awvalid,
  output logic                   o_s_axi_awready,
  input  wire logic [31:0]       i_s_axi_wdata,
  input  wire logic [3:0]        i_s_axi_wstrb,
  input  wire logic              i_s_axi_wvalid,
  output logic                   o_s_axi_wready,
  output logic [1:0]             o_s_axi_bresp,
  output logic                   o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic              i_s_axi_arvalid,
  output logic                   o_s_axi_arready,
  output logic [31:0]            o_s_axi_rdata,
  output logic [1:0]             o_s_axi_rresp,
  output logic                   o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    itoc_seq_t        seq;
    logic [1:0]       ph;
    logic [23:0]      tick;
    logic [31:0]      ratio;
    logic [24:0]      inc_min;
    logic [24:0]      inc_def;
    logic [2:0][24:0] acc;
    logic [2:0][19:0] rst_tenths;
    itoc_flags_t      flags;
    logic             gen_start;
    logic             gen_trip;
    logic [3:0]       mode;
    logic [15:0]      start_set;
    logic [15:0]      tms;
    logic [15:0]      min_ms;
    logic [15:0]      def_ms;
    logic [15:0]      rst_ms;
    logic [5:0]       irq_stat;
    logic [5:0]       irq_mask;
    logic             aw_got;
    logic             w_got;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
  } itoc_state_t;

  localparam itoc_state_t STATE_RST = '{
    seq: SEQ_IDLE, mode: CTRL_RST, start_set: START_RST, tms: TMS_RST,
    min_ms: DELAY_RST, def_ms: DELAY_RST, rst_ms: DELAY_RST, default: '0
  };

  itoc_state_t s_q;
  itoc_state_t s_d;

  // ---------------------------------------------------------------------------
  // Arithmetic helpers
  // ---------------------------------------------------------------------------
  // Full-width restoring divide; a zero divisor yields all ones so that the
  // callers saturate instead of stalling a phase.
  function automatic logic [63:0] div64(input logic [63:0] n, input logic [63:0] dv);
    logic [63:0] q;
    logic [64:0] rem;
    q   = '0;
    rem = '0;
    if (dv == 64'h0) begin
      q = '1;
    end else begin
      for (int i = 63; i >= 0; i--) begin
        rem = {rem[63:0], n[i]};
        if (rem >= {1'b0, dv}) begin
          rem  = rem - {1'b0, dv};
          q[i] = 1'b1;
        end
      end
    end
    return q;
  endfunction : div64

  function automatic logic [24:0] sat_acc(input logic [63:0] v);
    return (v > 64'(ACC_FULL)) ? ACC_FULL : v[24:0];
  endfunction : sat_acc

  // Ratio raised to alpha, minus one, in Q16. The 0.02 power is taken as
  // x = 0.02 * ln(ratio) from a piecewise linear log2, plus x squared over two,
  // which keeps the curve within about two percent at a ratio of twenty.
  function automatic logic [31:0] curve_term(input logic [31:0] r, input itoc_alpha_t a);
    logic [63:0] sq;
    logic [31:0] lg;
    logic [31:0] t;
    int          msb;
    sq  = 64'(r) * 64'(r);
    msb = 16;
    t   = 32'h0;
    for (int i = 16; i < 32; i++) begin
      if (r[i]) begin
        msb = i;
      end
    end
    lg = (32'(msb - 16) << 16) + ((r >> (msb - 16)) - RATIO_ONE);
    if (r > RATIO_ONE) begin
      unique case (a)
        ALPHA_1:   t = r - RATIO_ONE;
        ALPHA_2:   t = sq[47:16] - RATIO_ONE;
        ALPHA_002: begin
          t = 32'((64'(lg) * LN_ALPHA002) >> 16);
          t = t + 32'((64'(t) * 64'(t)) >> 17);
        end
        default:   t = 32'h0;
      endcase
    end
    return t;
  endfunction : curve_term

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // ---------------------------------------------------------------------------
  // Bus handshakes
  // ---------------------------------------------------------------------------
  assign o_s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign o_s_axi_wready  = !s_q.w_got && !s_q.bvalid;
  assign o_s_axi_arready = !s_q.rvalid;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin : next_state
    logic [2:0][15:0] cur;
    itoc_curve_t      crv;
    logic [63:0]      num;
    logic [63:0]      den;
    logic [63:0]      quo;
    logic [31:0]      d;
    logic [31:0]      r2;
    logic [24:0]      step;
    logic [24:0]      aval;
    logic [19:0]      rcnt;
    logic             above;
    logic             run;
    logic             iec;
    logic [5:0]       ev;
    logic [5:0]       clr;
    cur   = {i_phase3_fundamental_rms, i_phase2_fundamental_rms, i_phase1_fundamental_rms};
    crv   = curve_of(s_q.mode);
    num   = 64'h0;
    den   = 64'h0;
    step  = 25'h0;
    aval  = s_q.acc[s_q.ph];
    rcnt  = s_q.rst_tenths[s_q.ph];
    above = cur[s_q.ph] > s_q.start_set;
    run   = (s_q.mode != MODE_OFF) && (s_q.mode <= MODE_ANSI_LEXT) && !i_block;
    iec   = (s_q.mode >= MODE_IEC_INV) && (s_q.mode <= MODE_IEC_LONG);
    d     = curve_term(s_q.ratio, crv.alpha);
    r2    = 32'((64'(s_q.ratio) * 64'(s_q.ratio)) >> 16);
    clr   = 6'h0;
    s_d   = s_q;

    // Divider operands for the current sequencer step.
    unique case (s_q.seq)
      SEQ_MIN: begin
        num = FULL_TS;
        den = 64'(s_q.min_ms) * TENTHS_PER_MS;
      end
      SEQ_DEF: begin
        num = FULL_TS;
        den = 64'(s_q.def_ms) * TENTHS_PER_MS;
      end
      SEQ_RATIO: begin
        num = {32'h0, cur[s_q.ph], 16'h0};
        den = 64'(s_q.start_set);
      end
      SEQ_UPDATE: begin
        if (above) begin
          num = OP_SCALE * 64'(d);
          den = 64'(s_q.tms) * ((64'(crv.k) << 16) + 64'(crv.c) * 64'(d));
        end else begin
          num = OP_SCALE * 64'((r2 < RATIO_ONE) ? (RATIO_ONE - r2) : 32'h0);
          den = 64'(s_q.tms) * (64'(crv.kr) << 16);
        end
      end
      default: begin
        num = 64'h0;
        den = 64'h0;
      end
    endcase
    quo = div64(num, den);

    // -------------------------------------------------------------------------
    // Sample sequencer: one pass over the three phases per sample period.
    // -------------------------------------------------------------------------
    s_d.tick = (s_q.tick == 24'(SAMPLE_CYCLES - 1)) ? 24'h0 : s_q.tick + 24'h1;
    unique case (s_q.seq)
      SEQ_IDLE: begin
        if (s_q.tick == 24'(SAMPLE_CYCLES - 1)) begin
          s_d.seq = SEQ_MIN;
        end
      end
      SEQ_MIN: begin
        s_d.inc_min = sat_acc(quo);
        s_d.seq     = SEQ_DEF;
      end
      SEQ_DEF: begin
        s_d.inc_def = sat_acc(quo);
        s_d.ph      = 2'h0;
        s_d.seq     = SEQ_RATIO;
      end
      SEQ_RATIO: begin
        s_d.ratio = (quo > 64'(RATIO_SAT)) ? RATIO_SAT : quo[31:0];
        s_d.seq   = SEQ_UPDATE;
      end
      SEQ_UPDATE: begin
        if (above) begin
          rcnt = 20'h0;
          if (s_q.mode == MODE_DEFINITE) begin
            step = s_q.inc_def;
          end else begin
            step = (sat_acc(quo) < s_q.inc_min) ? sat_acc(quo) : s_q.inc_min;
          end
          aval = sat_acc(64'(aval) + 64'(step));
        end else if (s_q.mode == MODE_DEFINITE) begin
          aval = 25'h0;
          rcnt = 20'h0;
        end else if (iec) begin
          rcnt = rcnt + 20'(TS_TENTHS_MS);
          if (64'(rcnt) >= 64'(s_q.rst_ms) * TENTHS_PER_MS) begin
            aval = 25'h0;
            rcnt = 20'h0;
          end
        end else begin
          aval = (sat_acc(quo) >= aval) ? 25'h0 : aval - sat_acc(quo);
        end
        s_d.acc[s_q.ph]        = aval;
        s_d.rst_tenths[s_q.ph] = rcnt;
        s_d.flags.start[s_q.ph] = above;
        s_d.flags.trip[s_q.ph]  = above && (aval == ACC_FULL);
        s_d.ph  = s_q.ph + 2'h1;
        s_d.seq = (s_q.ph == 2'h2) ? SEQ_IDLE : SEQ_RATIO;
      end
      default: begin
        s_d.seq = SEQ_IDLE;
      end
    endcase

    // Off or blocked wins over any update made in the same cycle.
    if (!run) begin
      s_d.acc        = '0;
      s_d.rst_tenths = '0;
      s_d.flags      = '0;
    end
    s_d.gen_start = |s_d.flags.start;
    s_d.gen_trip  = |s_d.flags.trip;

    // -------------------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------------------
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = i_s_axi_wdata;
      s_d.wstrb = i_s_axi_wstrb;
    end
    if (s_q.aw_got && s_q.w_got) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      unique case ({s_q.awaddr[7:2], 2'b00})
        REG_CTRL:      s_d.mode = 4'(wmerge(32'(s_q.mode), s_q.wdata, s_q.wstrb));
        REG_START:     s_d.start_set = 16'(wmerge(32'(s_q.start_set), s_q.wdata, s_q.wstrb));
        REG_TMS:       s_d.tms = 16'(wmerge(32'(s_q.tms), s_q.wdata, s_q.wstrb));
        REG_MIN_DELAY: s_d.min_ms = 16'(wmerge(32'(s_q.min_ms), s_q.wdata, s_q.wstrb));
        REG_DEF_DELAY: s_d.def_ms = 16'(wmerge(32'(s_q.def_ms), s_q.wdata, s_q.wstrb));
        REG_RST_DELAY: s_d.rst_ms = 16'(wmerge(32'(s_q.rst_ms), s_q.wdata, s_q.wstrb));
        REG_STATUS:    s_d.bresp = RESP_OKAY;
        REG_IRQ_STAT:  clr = 6'(wmerge(32'h0, s_q.wdata, s_q.wstrb));
        REG_IRQ_MASK:  s_d.irq_mask = 6'(wmerge(32'(s_q.irq_mask), s_q.wdata, s_q.wstrb));
        default:       s_d.bresp = RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && i_s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Rising start and trip flags are sticky; a new event beats a clear.
    ev           = {s_d.flags.trip & ~s_q.flags.trip, s_d.flags.start & ~s_q.flags.start};
    s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;

    // -------------------------------------------------------------------------
    // Register reads
    // -------------------------------------------------------------------------
    if (i_s_axi_arvalid && o_s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      unique case ({i_s_axi_araddr[7:2], 2'b00})
        REG_CTRL:      s_d.rdata = 32'(s_q.mode);
        REG_START:     s_d.rdata = 32'(s_q.start_set);
        REG_TMS:       s_d.rdata = 32'(s_q.tms);
        REG_MIN_DELAY: s_d.rdata = 32'(s_q.min_ms);
        REG_DEF_DELAY: s_d.rdata = 32'(s_q.def_ms);
        REG_RST_DELAY: s_d.rdata = 32'(s_q.rst_ms);
        REG_STATUS:    s_d.rdata = 32'({i_block, s_q.gen_trip, s_q.gen_start, s_q.flags});
        REG_IRQ_STAT:  s_d.rdata = 32'(s_q.irq_stat);
        REG_IRQ_MASK:  s_d.rdata = 32'(s_q.irq_mask);
        default: begin
          s_d.rdata = 32'h0;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && i_s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end : next_state

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin : state_reg
    if (!i_rstn) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end : state_reg

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign o_phase_flags   = s_q.flags;
  assign o_general_start = s_q.gen_start;
  assign o_general_trip  = s_q.gen_trip;
  assign o_irq           = |(s_q.irq_stat & s_q.irq_mask);
  assign o_s_axi_bvalid  = s_q.bvalid;
  assign o_s_axi_bresp   = s_q.bresp;
  assign o_s_axi_rvalid  = s_q.rvalid;
  assign o_s_axi_rresp   = s_q.rresp;
  assign o_s_axi_rdata   = s_q.rdata;

endmodule : itoc_core

// ---- bench/itoc_properties.sv ----
// Port assertions for the three-phase overcurrent block.
`timescale 1ns/1ps
module itoc_properties
  import itoc_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_rstn,
  input wire logic        i_block,
  input wire itoc_flags_t o_phase_flags,
  input wire logic        o_general_start,
  input wire logic        o_general_trip,
  input wire logic        i_s_axi_awvalid,
  input wire logic        o_s_axi_awready,
  input wire logic        i_s_axi_wvalid,
  input wire logic        o_s_axi_wready,
  input wire logic        o_s_axi_bvalid,
  input wire logic        i_s_axi_bready,
  input wire logic        o_s_axi_arready,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_s_axi_rready,
  input wire logic [31:0] o_s_axi_rdata
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  sequence s_wr_taken;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence s_blocked;
    i_block ##1 i_block;
  endsequence

  property p_gen_start; o_general_start == (|o_phase_flags.start); endproperty
  property p_gen_trip; o_general_trip == (|o_phase_flags.trip); endproperty
  property p_block;
    s_blocked |-> (o_phase_flags == 6'h00) && !o_general_start && !o_general_trip;
  endproperty
  property p_trip_start; (o_phase_flags.trip & ~o_phase_flags.start) == 3'h0; endproperty
  property p_wr_resp; s_wr_taken |-> ##[1:2] o_s_axi_bvalid; endproperty
  property p_b_hold; o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid; endproperty
  property p_r_hold;
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata);
  endproperty
  property p_ar_busy; o_s_axi_rvalid |-> !o_s_axi_arready; endproperty

  a_gen_start: assert property (p_gen_start) else $error("general start wrong");
  a_gen_trip: assert property (p_gen_trip) else $error("general trip wrong");
  a_block: assert property (p_block) else $error("outputs active while blocked");
  a_trip_start: assert property (p_trip_start) else $error("trip without start");
  a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_ar_busy: assert property (p_ar_busy) else $error("read address taken while busy");
endmodule : itoc_properties

bind itoc_core itoc_properties u_props (.*);

// ---- bench/itoc_frontend.sv ----
// Model of the current measurement front end feeding the block.
`timescale 1ns/1ps
module itoc_frontend
  import itoc_pkg::*;
#(
  parameter int SC = 32
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [47:0] i_want,
  output logic      [47:0] o_cur
);
  logic [7:0] cnt_q;

  // New magnitudes land mid-sample, so they never change during a decision pass.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= 8'h00;
      o_cur <= 48'h0;
    end else begin
      cnt_q <= (cnt_q == 8'(SC - 1)) ? 8'h00 : cnt_q + 8'h01;
      if (cnt_q == 8'(SC / 2)) o_cur <= i_want;
    end
  end
endmodule : itoc_frontend

// ---- bench/tb_top.sv ----
// Self-checking bench for the three-phase overcurrent block.
`timescale 1ns/1ps
module tb_top
  import itoc_pkg::*;
;
  localparam int SC = 32;
  localparam logic [47:0] HI = {3{16'h1388}};
  logic        clk = 0, rstn = 0, blk = 0, gs, gt, irq;
  logic [47:0] want = '0, cur;
  itoc_flags_t flags;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd_v;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rd_r, wr_r;
  int          mismatches = 0, n_checks = 0, n;

  always #5 clk = ~clk;

  itoc_core #(.SAMPLE_CYCLES(SC)) uut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_phase1_fundamental_rms(cur[15:0]),
    .i_phase2_fundamental_rms(cur[31:16]), .i_phase3_fundamental_rms(cur[47:32]),
    .i_block(blk), .o_phase_flags(flags), .o_general_start(gs), .o_general_trip(gt),
    .o_irq(irq), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));
  itoc_frontend #(.SC(SC)) u_fe (.i_clk(clk), .i_rstn(rstn), .i_want(want), .o_cur(cur));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  // Ready levels are read at the falling edge, where they are settled until the next rise.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit pa, pw, b;
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    pa = 1;
    pw = 1;
    do begin
      @(negedge clk);
      {b, wr_r} = {bvalid, bresp};
      {pa, pw} = {pa && !awready, pw && !wready};
      @(posedge clk);
      if (!pa) awvalid <= 0;
      if (!pw) wvalid <= 0;
    end while (!b);
    bready <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit pa, v;
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(negedge clk);
      pa = arvalid && arready;
      {v, d, r} = {rvalid, rdata, rresp};
      @(posedge clk);
      if (pa) arvalid <= 0;
    end while (!v);
    rready <= 0;
  endtask : rd

  task automatic wait_f(input bit tr, input logic v, output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while ((tr ? gt : gs) !== v && c < 20000);
  endtask : wait_f

  task automatic t_regs();
    logic [7:0] ad [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
    logic [31:0] ex [7] = '{32'h0, 32'hC8, 32'hC8, 32'h64, 32'h64, 32'h64, 32'h0};
    foreach (ad[i]) begin
      rd(ad[i], rd_v, rd_r);
      check("reset value", rd_v, ex[i]);
    end
    rd(8'h40, rd_v, rd_r);
    check("unmapped resp", 32'(rd_r), 32'h2);
    wr(8'h40, 32'h1);
    check("unmapped write resp", 32'(wr_r), 32'h2);
  endtask : t_regs

  task automatic t_def();
    wr(REG_DEF_DELAY, 32'h4);
    wr(REG_CTRL, 32'h1);
    want <= 48'h0000_0100_0000;
    wait_f(0, 1, n);
    check("phase start", 32'(flags.start), 32'h2);
    wait_f(1, 1, n);
    check("definite delay", n, 3 * SC);
    check("flags", 32'(flags), 32'h12);
    rd(REG_STATUS, rd_v, rd_r);
    check("status", rd_v, 32'hD2);
    rd(REG_IRQ_STAT, rd_v, rd_r);
    check("irq status", rd_v, 32'h12);
    check("irq masked", 32'(irq), 32'h0);
    wr(REG_IRQ_MASK, 32'h10);
    check("irq raised", 32'(irq), 32'h1);
    wr(REG_IRQ_STAT, 32'h10);
    check("irq cleared", 32'(irq), 32'h0);
    blk <= 1;
    repeat (2) @(negedge clk);
    check("blocked", 32'({gs, gt, flags}), 32'h0);
    @(posedge clk);
    {blk, want} <= '0;
  endtask : t_def

  task automatic t_curve(input logic [3:0] m, input real e);
    real d;
    wr(REG_CTRL, 32'h0);
    want <= '0;
    repeat (2 * SC) @(negedge clk);
    check("off", 32'({gs, gt, flags}), 32'h0);
    @(posedge clk);
    want <= HI;
    wr(REG_CTRL, 32'(m));
    wait_f(0, 1, n);
    wait_f(1, 1, n);
    d = n * 1.0 / SC + 1 - e;
    check("curve time", 32'((d < 0 ? -d : d) <= e * 0.03 + 2.0), 32'h1);
  endtask : t_curve

  task automatic t_curves();
    real k [11] = '{0.14, 13.5, 80.0, 120.0, 0.0086, 0.0515, 19.61, 28.2, 0.086, 28.55, 64.07};
    real c [11] = '{0.0, 0.0, 0.0, 0.0, 0.0185, 0.114, 0.491, 0.1217, 0.185, 0.712, 0.25};
    real a [11] = '{0.02, 1.0, 2.0, 1.0, 0.02, 0.02, 2.0, 2.0, 0.02, 2.0, 2.0};
    wr(REG_TMS, 32'h5);
    wr(REG_MIN_DELAY, 32'h1);
    for (int i = 0; i < 11; i++) t_curve(4'(i + 2), 50.0 * (k[i] / (20.0 ** a[i] - 1.0) + c[i]));
    wr(REG_MIN_DELAY, 32'd200);
    t_curve(4'h9, 200.0);
  endtask : t_curves

  // A short dip keeps the IEC timing state and only slightly unwinds the ANSI one; a dip beyond the reset delay restarts it.
  task automatic t_reset();
    wr(REG_MIN_DELAY, 32'h1);
    wr(REG_RST_DELAY, 32'd20);
    for (int i = 0; i < 2; i++) begin
      t_curve(i ? 4'h6 : 4'h3, i ? 7.89 : 35.53);
      for (int j = 0; j < 2; j++) begin
        @(posedge clk);
        want <= '0;
        repeat ((j ? 30 : 2) * SC) @(posedge clk);
        want <= HI;
        wait_f(1, 1, n);
        check("reset delay", 32'(j ? n > (i ? 5 : 20) * SC : n < 3 * SC), 32'h1);
      end
    end
  endtask : t_reset

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    t_regs();
    t_def();
    t_curves();
    t_reset();
    wrap_up();
  end

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule : tb_top
